// [tdm_line_pkg.sv]
// shared constants and carrier types for the tdm line interface
package tdm_line_pkg;
    // apb register byte offsets
    localparam logic [7:0] TX_CTRL_TWO_OFS = 8'h00;
    localparam logic [7:0] TX_CONFIG_OFS = 8'h04;
    localparam logic [7:0] RX_CTRL_TWO_OFS = 8'h08;
    localparam logic [7:0] RX_CONFIG_OFS = 8'h0C;
    localparam logic [7:0] TX_DATA_OFS = 8'h10;
    localparam logic [7:0] RX_DATA_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // field positions
    localparam int TX_FRAME_PULSE_DIR_BIT = 0;
    localparam int TX_LINE_MODE_SEL_BIT = 1;
    localparam int TX_LAUNCH_EDGE_SEL_BIT = 2;
    localparam int TX_LINE_CLOCK_SRC_BIT = 6;
    localparam int DIAG_LOOPBACK_EN_BIT = 0;
    localparam int RX_LINE_MODE_SEL_BIT = 1;
    localparam int RX_SAMPLE_EDGE_SEL_BIT = 2;
    localparam int T1_E1_SEL_BIT = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // frame geometry
    localparam int T1_FRAME_BITS = 193;
    localparam int E1_FRAME_BITS = 256;
    localparam logic [4:0] E1_TS0 = 5'h00;
    localparam logic [4:0] E1_TS16 = 5'h10;
    // system clock is half the input clock, divided by eight: toggle every 8 input cycles
    localparam int DIAG_CLK_HALF_CYCLES = 8;

    typedef struct packed {
        logic line_clock;
        logic data;
        logic frame_pulse;
    } line_s;

    typedef struct packed {
        logic frame_pulse_mode;
        logic is_e1;
        logic edge_sel;
    } lane_cfg_s;
endpackage

// [tdm_edge_sync.sv]
// two-flop synchroniser of line pins plus active-edge detection
`timescale 1ns/1ps
`default_nettype none
module tdm_edge_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // line side
    input wire tdm_line_pkg::line_s i_line,
    input wire logic i_edge_sel,
    // synchronised outputs
    output logic o_tick,
    output logic o_data,
    output logic o_frame_pulse
);
    tdm_line_pkg::line_s meta_q;
    tdm_line_pkg::line_s sync_q;
    logic clk_last_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
            clk_last_q <= 1'b0;
        end else begin
            meta_q <= i_line;
            sync_q <= meta_q;
            clk_last_q <= sync_q.line_clock;
        end
    end
    // edge_sel high selects the falling edge
    wire rise = sync_q.line_clock & ~clk_last_q;
    wire fall = ~sync_q.line_clock & clk_last_q;
    assign o_tick = i_edge_sel ? fall : rise;
    assign o_data = sync_q.data;
    assign o_frame_pulse = sync_q.frame_pulse;
endmodule
`default_nettype wire

// [tdm_slot_counter.sv]
// frame position counter: marks positions that carry no cell bits
`timescale 1ns/1ps
`default_nettype none
module tdm_slot_counter (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire tdm_line_pkg::lane_cfg_s i_cfg,
    input wire logic i_tick,
    input wire logic i_frame_pulse,
    // result
    output logic o_skip
);
    logic [7:0] pos_q;
    logic [7:0] pos_d;
    // the e1 pulse marks bit 0, so the pulsed position is itself bit 0
    wire [7:0] cur_pos = i_frame_pulse ? 8'h00 : pos_q;
    wire [4:0] slot = cur_pos[7:3];
    wire e1_skip = (slot == tdm_line_pkg::E1_TS0) || (slot == tdm_line_pkg::E1_TS16);
    // t1 excludes only the pulse position; e1 excludes ts0 and ts16
    assign o_skip = i_cfg.frame_pulse_mode &
                    (i_cfg.is_e1 ? e1_skip : i_frame_pulse);
    always_comb begin
        pos_d = pos_q;
        if (i_tick) begin
            pos_d = cur_pos + 8'h01;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pos_q <= 8'h00;
        end else begin
            pos_q <= pos_d;
        end
    end
endmodule
`default_nettype wire

// [tdm_line_if.sv]
// tdm line interface: apb registers, octet serialiser and deserialiser
// Summary of operation
// RULE1: tx control bit picks gapped clock or clock plus frame pulse operation.
// RULE2: tx frame-pulse mode sends no cell bits at t1 pulse or e1 ts0/ts16.
// RULE3: e1 pulse marks frame bit 0; ts0 and ts16 counted from it.
// RULE4: tx config bit chooses t1 or e1 framing.
// RULE5: tx octets aligned to byte positions counted from the frame pulse.
// RULE6: clear e1 transmit sends a cell bit on every active clock edge.
// RULE7: direction bit selects driving or accepting the tx frame pulse.
// RULE8: control bit selects tx launch edge, opposite to framer sampling.
// RULE9: octets go out msb first, lsb eighth.
// RULE10: fractional t1 gapped mode: framer gaps clock over overhead and idle channels.
// RULE11: fractional t1 pulse mode: framer pulses over unused positions; no internal pulse.
// RULE12: fractional e1 uses gapped clock only; pulse mode unsupported.
// RULE13: control bit selects framer clock or system clock divided by eight.
// RULE14: rx frame-pulse mode discards t1 pulse bits or e1 ts0/ts16 bits.
// RULE15: rx config bit selects t1/e1; without pulse mode every edge is data.
// RULE16: clear e1 receive ignores the pulse input and samples every edge.
// RULE17: control bit selects rx sampling edge, opposite to the launcher.
// RULE18: loopback takes rx clock, data and pulse from the local transmitter.
// RULE19: in loopback software matches rx mode to tx and opposes the edges.
// RULE20: fractional t1 rx pulse mode: framer pulses over unused positions.
// RULE21: fractional e1 receive uses gapped clock; rx pulse mode unsupported.
// RULE22: rx counter and assembler advance only on active non-excluded edges.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tdm_line_if (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // transmit line
    input wire logic i_tx_line_clock,
    input wire logic i_tx_frame_pulse,
    output logic o_tx_line_clock,
    output logic o_tx_data,
    output logic o_tx_frame_pulse,
    output logic o_tx_frame_pulse_oe_n,
    // receive line
    input wire tdm_line_pkg::line_s i_rx_line
);
    // registers
    logic [7:0] tx_ctrl_two_q;
    logic [7:0] tx_config_q;
    logic [7:0] rx_ctrl_two_q;
    logic [7:0] rx_config_q;
    logic [7:0] tx_hold_q;
    logic tx_hold_full_q;
    logic [7:0] rx_hold_q;
    logic rx_hold_full_q;
    logic rx_overrun_q;
    logic rx_fresh_q;
    logic tx_underrun_q;
    // transmit datapath
    logic [7:0] tx_shift_q;
    logic [2:0] tx_bit_q;
    logic tx_data_q;
    logic tx_fp_q;
    logic [2:0] div_cnt_q;
    logic diag_clk_q;
    logic [7:0] tx_pos_q;
    // receive datapath
    logic [7:0] rx_shift_q;
    logic [2:0] rx_bit_q;

    wire tx_line_mode_sel = tx_ctrl_two_q[tdm_line_pkg::TX_LINE_MODE_SEL_BIT];
    wire tx_frame_pulse_dir = tx_ctrl_two_q[tdm_line_pkg::TX_FRAME_PULSE_DIR_BIT];
    wire tx_launch_edge_sel = tx_ctrl_two_q[tdm_line_pkg::TX_LAUNCH_EDGE_SEL_BIT];
    wire tx_line_clock_src = tx_ctrl_two_q[tdm_line_pkg::TX_LINE_CLOCK_SRC_BIT];
    wire tx_t1_e1_sel = tx_config_q[tdm_line_pkg::T1_E1_SEL_BIT];
    wire diag_loopback_en = rx_ctrl_two_q[tdm_line_pkg::DIAG_LOOPBACK_EN_BIT];
    wire rx_line_mode_sel = rx_ctrl_two_q[tdm_line_pkg::RX_LINE_MODE_SEL_BIT];
    wire rx_sample_edge_sel = rx_ctrl_two_q[tdm_line_pkg::RX_SAMPLE_EDGE_SEL_BIT];
    wire rx_t1_e1_sel = rx_config_q[tdm_line_pkg::T1_E1_SEL_BIT];

    // apb decode: zero wait states, unmapped offsets answer pslverr
    // read data is latched in the setup cycle so that it stands at the ready edge
    wire access = i_psel & i_penable;
    wire wr = access & i_pwrite;
    wire rd = access & ~i_pwrite;
    wire setup_rd = i_psel & ~i_penable & ~i_pwrite;
    wire hit_txc = (i_paddr == tdm_line_pkg::TX_CTRL_TWO_OFS);
    wire hit_txf = (i_paddr == tdm_line_pkg::TX_CONFIG_OFS);
    wire hit_rxc = (i_paddr == tdm_line_pkg::RX_CTRL_TWO_OFS);
    wire hit_rxf = (i_paddr == tdm_line_pkg::RX_CONFIG_OFS);
    wire hit_txd = (i_paddr == tdm_line_pkg::TX_DATA_OFS);
    wire hit_rxd = (i_paddr == tdm_line_pkg::RX_DATA_OFS);
    wire hit_sts = (i_paddr == tdm_line_pkg::STATUS_OFS);
    wire mapped = hit_txc | hit_txf | hit_rxc | hit_rxf | hit_txd | hit_rxd | hit_sts;
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~mapped;
    wire [31:0] status_word = {28'h0000000, tx_underrun_q, rx_overrun_q,
                               rx_hold_full_q, ~tx_hold_full_q};
    wire [7:0] reg_mux = hit_txc ? tx_ctrl_two_q :
                         hit_txf ? tx_config_q :
                         hit_rxc ? rx_ctrl_two_q :
                         hit_rxf ? rx_config_q :
                         hit_rxd ? rx_hold_q : 8'h00;
    wire [31:0] rd_word = hit_sts ? status_word : {24'h000000, reg_mux};

    // diagnostic clock: input clock halved then divided by eight
    wire div_wrap = (div_cnt_q == 3'(tdm_line_pkg::DIAG_CLK_HALF_CYCLES - 1));
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_cnt_q <= 3'h0;
            diag_clk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_q + 3'h1;
            if (div_wrap) begin
                diag_clk_q <= ~diag_clk_q; // see RULE13
            end
        end
    end

    // transmit clock: framer pin, or internal clock taken straight into the edge detector
    tdm_line_pkg::line_s tx_pins;
    assign tx_pins.line_clock = i_tx_line_clock;
    assign tx_pins.data = 1'b0;
    assign tx_pins.frame_pulse = i_tx_frame_pulse;
    logic ext_tick;
    logic ext_fp;
    tdm_edge_sync u_tx_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_line(tx_pins),
        .i_edge_sel(tx_launch_edge_sel),
        .o_tick(ext_tick),
        .o_data(),
        .o_frame_pulse(ext_fp)
    );
    logic diag_last_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            diag_last_q <= 1'b0;
        end else begin
            diag_last_q <= diag_clk_q;
        end
    end
    wire diag_rise = diag_clk_q & ~diag_last_q;
    wire diag_fall = ~diag_clk_q & diag_last_q;
    wire diag_tick = tx_launch_edge_sel ? diag_fall : diag_rise;
    wire tx_tick = tx_line_clock_src ? diag_tick : ext_tick; // see RULE13 RULE8

    // own frame pulse when sourced here; framer pulse otherwise
    wire own_wrap = tx_t1_e1_sel ?
        (tx_pos_q == 8'(tdm_line_pkg::E1_FRAME_BITS - 1)) :
        (tx_pos_q == 8'(tdm_line_pkg::T1_FRAME_BITS - 1));
    wire own_fp = (tx_pos_q == 8'h00);
    wire tx_fp_now = tx_frame_pulse_dir ? own_fp : ext_fp; // see RULE7
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_pos_q <= 8'h00;
        end else if (tx_tick) begin
            tx_pos_q <= own_wrap ? 8'h00 : tx_pos_q + 8'h01;
        end
    end

    tdm_line_pkg::lane_cfg_s tx_cfg;
    assign tx_cfg.frame_pulse_mode = tx_line_mode_sel; // see RULE1 RULE6 RULE12
    assign tx_cfg.is_e1 = tx_t1_e1_sel; // see RULE4
    assign tx_cfg.edge_sel = tx_launch_edge_sel;
    logic tx_skip;
    tdm_slot_counter u_tx_slot (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cfg(tx_cfg),
        .i_tick(tx_tick),
        .i_frame_pulse(tx_fp_now),
        .o_skip(tx_skip)
    );

    // idle octets advance the bit counter too, so a late write still lands on a byte position
    wire tx_byte_start = (tx_bit_q == 3'h0);
    wire tx_send = tx_tick & ~tx_skip; // see RULE2 RULE3
    wire tx_load = tx_send & tx_byte_start & tx_hold_full_q; // see RULE5
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_shift_q <= 8'h00;
            tx_bit_q <= 3'h0;
            tx_data_q <= 1'b0;
            tx_fp_q <= 1'b0;
        end else if (tx_tick) begin
            tx_fp_q <= tx_fp_now;
            if (!tx_send) begin
                // idle fill in an excluded slot; the pulse position restarts the octet
                tx_data_q <= 1'b1;
                if (tx_fp_now) begin
                    tx_bit_q <= 3'h0; // see RULE5
                end
            end else if (tx_byte_start) begin
                tx_data_q <= tx_load ? tx_hold_q[7] : 1'b1; // see RULE9
                tx_shift_q <= tx_load ? {tx_hold_q[6:0], 1'b1} : 8'hFF;
                tx_bit_q <= 3'h1;
            end else begin
                tx_data_q <= tx_shift_q[7]; // see RULE9
                tx_shift_q <= {tx_shift_q[6:0], 1'b1};
                tx_bit_q <= tx_bit_q + 3'h1;
            end
        end
    end
    wire tx_underrun_ev = tx_send & tx_byte_start & ~tx_hold_full_q;

    assign o_tx_data = tx_data_q;
    assign o_tx_frame_pulse = tx_fp_q;
    assign o_tx_frame_pulse_oe_n = ~tx_frame_pulse_dir; // see RULE7
    assign o_tx_line_clock = diag_clk_q;

    // receive: loopback substitutes the local transmit signals
    tdm_line_pkg::line_s loop_line;
    assign loop_line.line_clock = tx_line_clock_src ? diag_clk_q : i_tx_line_clock;
    assign loop_line.data = tx_data_q;
    assign loop_line.frame_pulse = tx_fp_q;
    wire tdm_line_pkg::line_s rx_src = diag_loopback_en ? loop_line : i_rx_line; // see RULE18
    logic rx_tick;
    logic rx_bit;
    logic rx_fp;
    tdm_edge_sync u_rx_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_line(rx_src),
        .i_edge_sel(rx_sample_edge_sel), // see RULE17
        .o_tick(rx_tick),
        .o_data(rx_bit),
        .o_frame_pulse(rx_fp)
    );
    tdm_line_pkg::lane_cfg_s rx_cfg;
    assign rx_cfg.frame_pulse_mode = rx_line_mode_sel; // see RULE14 RULE16 RULE21
    assign rx_cfg.is_e1 = rx_t1_e1_sel; // see RULE15
    assign rx_cfg.edge_sel = rx_sample_edge_sel;
    logic rx_skip;
    tdm_slot_counter u_rx_slot (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cfg(rx_cfg),
        .i_tick(rx_tick),
        .i_frame_pulse(rx_fp),
        .o_skip(rx_skip)
    );
    wire rx_take = rx_tick & ~rx_skip; // see RULE22
    wire rx_octet_done = rx_take & (rx_bit_q == 3'h7);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_shift_q <= 8'h00;
            rx_bit_q <= 3'h0;
        end else if (rx_take) begin
            rx_shift_q <= {rx_shift_q[6:0], rx_bit}; // see RULE22
            rx_bit_q <= rx_bit_q + 3'h1;
        end
    end

    // register writes; hardware sets win over software clears
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_ctrl_two_q <= tdm_line_pkg::CTRL_RESET;
            tx_config_q <= tdm_line_pkg::CTRL_RESET;
            rx_ctrl_two_q <= tdm_line_pkg::CTRL_RESET;
            rx_config_q <= tdm_line_pkg::CTRL_RESET;
            tx_hold_q <= 8'h00;
            tx_hold_full_q <= 1'b0;
            rx_hold_q <= 8'h00;
            rx_hold_full_q <= 1'b0;
            rx_overrun_q <= 1'b0;
            tx_underrun_q <= 1'b0;
            rx_fresh_q <= 1'b0;
            o_prdata <= 32'h00000000;
        end else begin
            if (wr && hit_txc) tx_ctrl_two_q <= i_pwdata[7:0];
            if (wr && hit_txf) tx_config_q <= i_pwdata[7:0];
            if (wr && hit_rxc) rx_ctrl_two_q <= i_pwdata[7:0];
            if (wr && hit_rxf) rx_config_q <= i_pwdata[7:0];
            if (wr && hit_txd && !tx_hold_full_q) begin
                tx_hold_q <= i_pwdata[7:0];
                tx_hold_full_q <= 1'b1;
            end else if (tx_load) begin
                tx_hold_full_q <= 1'b0;
            end
            if (rx_octet_done) begin
                rx_hold_q <= {rx_shift_q[6:0], rx_bit};
                rx_hold_full_q <= 1'b1;
            end else if (rd && hit_rxd && !rx_fresh_q) begin
                // a byte landing at the setup edge was not the one read, so it stays
                rx_hold_full_q <= 1'b0;
            end
            rx_fresh_q <= rx_octet_done;
            if (rx_octet_done && rx_hold_full_q && !(rd && hit_rxd)) begin
                rx_overrun_q <= 1'b1;
            end else if (wr && hit_sts && i_pwdata[2]) begin
                rx_overrun_q <= 1'b0;
            end
            if (tx_underrun_ev) begin
                tx_underrun_q <= 1'b1;
            end else if (wr && hit_sts && i_pwdata[3]) begin
                tx_underrun_q <= 1'b0;
            end
            if (setup_rd) o_prdata <= rd_word;
        end
    end

    // checks
    property p_tx_skip_idle;
        @(posedge i_clk) disable iff (i_rst)
        (tx_tick && tx_skip) |=> (o_tx_data == 1'b1);
    endproperty
    a_tx_skip_idle: assert property (p_tx_skip_idle) else $error("cell bit sent in excluded slot"); // see RULE2
    property p_tx_msb_first;
        @(posedge i_clk) disable iff (i_rst)
        tx_load |=> (o_tx_data == $past(tx_hold_q[7]));
    endproperty
    a_tx_msb_first: assert property (p_tx_msb_first) else $error("octet not msb first"); // see RULE9
    property p_tx_align;
        @(posedge i_clk) disable iff (i_rst)
        (tx_tick && tx_skip && tx_fp_now) |=> (tx_bit_q == 3'h0);
    endproperty
    a_tx_align: assert property (p_tx_align) else $error("octet load off byte boundary"); // see RULE5
    property p_clear_no_skip;
        @(posedge i_clk) disable iff (i_rst)
        !tx_line_mode_sel |-> !tx_skip;
    endproperty
    a_clear_no_skip: assert property (p_clear_no_skip) else $error("gapped mode skipped a bit"); // see RULE6 RULE1
    property p_fp_dir;
        @(posedge i_clk) disable iff (i_rst)
        o_tx_frame_pulse_oe_n == !tx_ctrl_two_q[0];
    endproperty
    a_fp_dir: assert property (p_fp_dir) else $error("frame pulse direction wrong"); // see RULE7
    property p_rx_no_skip;
        @(posedge i_clk) disable iff (i_rst)
        !rx_line_mode_sel |-> !rx_skip;
    endproperty
    a_rx_no_skip: assert property (p_rx_no_skip) else $error("rx dropped bit in gapped mode"); // see RULE15 RULE16
    property p_rx_hold;
        @(posedge i_clk) disable iff (i_rst)
        (rx_tick && rx_skip) |=> $stable(rx_bit_q) && $stable(rx_shift_q);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx advanced on excluded bit"); // see RULE14 RULE22
    property p_diag_period;
        @(posedge i_clk) disable iff (i_rst)
        $rose(diag_clk_q) |=> diag_clk_q [*7] ##1 !diag_clk_q;
    endproperty
    a_diag_period: assert property (p_diag_period) else $error("diag clock period wrong"); // see RULE13
endmodule
`default_nettype wire

// [tdm_framer_model.sv]
// behavioural framer on the far side of the tdm line pins
`timescale 1ns/1ps
`default_nettype none
module tdm_framer_model (
    // clock
    input wire logic i_clk,
    // transmit line
    input wire logic i_tx_data,
    output logic o_tx_line_clock,
    output logic o_tx_frame_pulse,
    // receive line
    output var tdm_line_pkg::line_s o_rx_line
);
    logic cap [0:39];
    initial begin
        o_tx_line_clock = 1'h0;
        o_tx_frame_pulse = 1'h0;
        o_rx_line = '0;
    end
    task half();
        repeat (8) @(posedge i_clk);
    endtask
    // clock stands still outside a burst, which is how gapped positions look
    task tx_bits(input int n, input logic pulse, input logic fall);
        o_tx_line_clock <= fall;
        for (int p = 0; p < n; p++) begin
            o_tx_frame_pulse <= pulse && (p == 0);
            half();
            o_tx_line_clock <= ~fall;
            half();
            // sample on the edge opposite the launch edge
            o_tx_line_clock <= fall;
            cap[p] = i_tx_data;
        end
        o_tx_frame_pulse <= 1'h0;
    endtask
    task rx_bits(input logic [15:0] bits, input logic [15:0] fp, input int n,
                 input logic fall);
        o_rx_line.line_clock <= fall;
        for (int i = n - 1; i >= 0; i--) begin
            o_rx_line.data <= bits[i];
            o_rx_line.frame_pulse <= fp[i];
            half();
            o_rx_line.line_clock <= ~fall;
            half();
            o_rx_line.line_clock <= fall;
        end
        half();
        // released lines float: show the inverse so a late sample cannot pass by luck
        o_rx_line.data <= ~bits[0];
        o_rx_line.frame_pulse <= ~fp[0];
    endtask
endmodule
`default_nettype wire

// [test_tdm_line_if.sv]
// self-checking bench for the tdm line interface
`timescale 1ns/1ps
`default_nettype none
module test_tdm_line_if;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_line_clock, tfp_model, tfp_dev, tfp_oe_n, tfp_wire, tdata, int_clk;
    tdm_line_pkg::line_s rx_line;
    int n_mismatch = 0;
    int checked = 0;
    always #20 i_clk = ~i_clk;
    // shared pulse pin: the device owns it while its enable is low
    assign tfp_wire = tfp_oe_n ? tfp_model : tfp_dev;
    tdm_line_if tdm_line_if_inst (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tx_line_clock(tx_line_clock),
        .i_tx_frame_pulse(tfp_wire), .o_tx_line_clock(int_clk), .o_tx_data(tdata),
        .o_tx_frame_pulse(tfp_dev), .o_tx_frame_pulse_oe_n(tfp_oe_n), .i_rx_line(rx_line));
    tdm_framer_model tdm_framer_model_inst (.i_clk(i_clk), .i_tx_data(tdata),
        .o_tx_line_clock(tx_line_clock), .o_tx_frame_pulse(tfp_model), .o_rx_line(rx_line));
    task test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // read data stands through the access phase and is taken at the ready edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge i_clk);
            if (pready === 1'h1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            test_done();
        end
        err = pslverr;
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge i_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask
    task t_reset();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++) rdchk(8'(4 * i), 32'hFFFFFFFF, 32'h0);
        apb(1'h0, 8'h1C, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        chk({31'h0, tfp_oe_n}, 32'h1);
    endtask
    task t_fp_dir();
        wr(tdm_line_pkg::TX_CTRL_TWO_OFS, 32'h1);
        repeat (2) @(posedge i_clk);
        chk({31'h0, tfp_oe_n}, 32'h0);
        wr(tdm_line_pkg::TX_CTRL_TWO_OFS, 32'h0);
        repeat (2) @(posedge i_clk);
        chk({31'h0, tfp_oe_n}, 32'h1);
    endtask
    // excl leading positions must carry idle fill; octet 0x5A goes out msb first
    task tx_case(input logic [31:0] ctrl, input logic [31:0] cfg, input logic fall,
                 input logic pulse, input int excl);
        int k;
        logic [7:0] b;
        wr(tdm_line_pkg::TX_CTRL_TWO_OFS, ctrl);
        wr(tdm_line_pkg::TX_CONFIG_OFS, cfg);
        wr(tdm_line_pkg::TX_DATA_OFS, 32'h5A);
        tdm_framer_model_inst.tx_bits(40, pulse, fall);
        for (k = 0; k < 32; k++) if (tdm_framer_model_inst.cap[k] === 1'h0) break;
        for (int p = 0; p < excl; p++) chk({31'h0, tdm_framer_model_inst.cap[p]}, 32'h1);
        if (excl == 8) chk(32'(k % 8), 32'h0);
        for (int p = 0; p < 8; p++) b[7 - p] = tdm_framer_model_inst.cap[k + p];
        chk({24'h0, b}, 32'h5A);
    endtask
    task rx_case(input logic [31:0] ctrl, input logic [31:0] cfg, input logic [15:0] bits,
                 input logic [15:0] fp, input int n, input logic fall, input logic [31:0] exp);
        wr(tdm_line_pkg::RX_CTRL_TWO_OFS, ctrl);
        wr(tdm_line_pkg::RX_CONFIG_OFS, cfg);
        tdm_framer_model_inst.rx_bits(bits, fp, n, fall);
        rdchk(tdm_line_pkg::STATUS_OFS, 32'h2, 32'h2);
        rdchk(tdm_line_pkg::RX_DATA_OFS, 32'hFF, exp);
    endtask
    task t_loop();
        int i;
        int t;
        int rises;
        logic prev;
        logic [31:0] r;
        logic e;
        wr(tdm_line_pkg::TX_CTRL_TWO_OFS, 32'h41);
        wr(tdm_line_pkg::TX_CONFIG_OFS, 32'h0);
        wr(tdm_line_pkg::RX_CONFIG_OFS, 32'h0);
        wr(tdm_line_pkg::RX_CTRL_TWO_OFS, 32'h5);
        t = 0;
        rises = 0;
        prev = int_clk;
        for (i = 0; i < 100 && rises < 2; i++) begin
            @(posedge i_clk);
            if (int_clk === 1'h1 && prev === 1'h0) begin
                rises++;
                if (rises == 1) t = i;
            end
            prev = int_clk;
        end
        chk(32'(i - 1 - t), 32'h10);
        // external receive clock stands still, so only looped idle fill can arrive
        for (i = 0; i < 50; i++) begin
            apb(1'h0, tdm_line_pkg::STATUS_OFS, 32'h0, r, e);
            if (r[1] === 1'h1) break;
        end
        chk({31'h0, r[1]}, 32'h1);
        rdchk(tdm_line_pkg::RX_DATA_OFS, 32'hFF, 32'hFF);
        // the device sources the pulse now, once per 193-position frame
        for (i = 0; i < 4000; i++) begin
            @(posedge i_clk);
            if (tfp_dev === 1'h1) break;
        end
        chk({31'h0, tfp_dev}, 32'h1);
    endtask
    initial begin
        repeat (100000) @(posedge i_clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        t_reset();
        t_fp_dir();
        tx_case(32'h0, 32'h0, 1'h0, 1'h0, 0);
        tx_case(32'h2, 32'h0, 1'h0, 1'h1, 1);
        tx_case(32'h6, 32'h1, 1'h1, 1'h1, 8);
        tx_case(32'h0, 32'h1, 1'h0, 1'h0, 0);
        rx_case(32'h0, 32'h0, 16'h00A5, 16'h0000, 8, 1'h0, 32'hA5);
        rx_case(32'h2, 32'h0, 16'h013C, 16'h0100, 9, 1'h0, 32'h3C);
        rx_case(32'h6, 32'h1, 16'hFF5A, 16'h8000, 16, 1'h1, 32'h5A);
        rx_case(32'h0, 32'h1, 16'h0069, 16'h00FF, 8, 1'h0, 32'h69);
        t_loop();
        test_done();
    end
endmodule
`default_nettype wire
